// ### design/adc_frame_pkg.sv
// Overview of operation
// - Results leave as straight binary on every channel
// - Each span resolves into 65536 codes
// - Code steps are 312.50, 156.25, 78.125 microvolts
// - Chip select falling edge starts frame and conversion
// - Convert the channel chosen in previous frame
// - Sample at frame start, convert on internal clock
// - Chip select high means idle, no frame activity
// - All link transfers use serial clock falling edges
// - Take 16 configuration bits on first 16 edges
// - New configuration applies at next frame start
// - Output frame length follows output format setting
// - Serial output driven once chip select is low
// - Serial output low through first 15 edges
// - Result MSB at 16th edge, one bit after
// - Output low after frame, floats when deselected
// - Shift register takes chain input after MSB, or after the tag bits in tagged format
// - Long reset pulse powers down, short only resets
package adc_frame_pkg;

    // Conversion result and span figures
    localparam int CODE_W = 16;
    localparam int FULL_SCALE_CODES = 65536;
    localparam real LSB_UV_WIDE = 312.50;
    localparam real LSB_UV_MIDDLE = 156.25;
    localparam real LSB_UV_NARROW = 78.125;

    // Link framing
    localparam int CFG_W = 16;
    localparam int CFG_EDGES = 16;
    localparam int TAG_W = 8;

    // Timing, in the local clock rate
    localparam int MCLK_MHZ = 250;
    localparam int PD_MIN_NS = 400;
    localparam int RST_MAX_NS = 100;
    localparam int CONV_NS = 1000;
    localparam int PD_CYCLES = (PD_MIN_NS * MCLK_MHZ + 999) / 1000;
    localparam int RST_MAX_CYCLES = (RST_MAX_NS * MCLK_MHZ) / 1000;
    localparam int CONV_CYCLES = (CONV_NS * MCLK_MHZ + 999) / 1000;

    // Configuration word layout
    localparam int CMD_LSB = 12;
    localparam int CMD_W = 4;
    localparam int FMT_POS = 8;
    localparam int SPAN_LSB = 4;
    localparam int SPAN_W = 3;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 3;

    // Commands carried in the upper nibble
    localparam logic [3:0] PROGRAM_WRITE_CMD = 4'h5;
    localparam logic [3:0] AUTO_SEQUENCE_CMD = 4'ha;
    localparam logic [3:0] FIXED_CHANNEL_SELECT_CMD = 4'hc;

    // Reset values of the program registers
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] SPAN_RST = 3'h0;
    localparam logic FMT_RST = 1'b0;

    typedef struct packed {
        logic running;
        logic auto_seq;
        logic programmed;
        logic [CHAN_W-1:0] chan;
        logic [SPAN_W-1:0] full_scale_span;
        logic fmt;
    } cfg_s;

    localparam cfg_s CFG_RST = '{1'b0, 1'b0, 1'b0, CHAN_RST, SPAN_RST, FMT_RST};

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [TAG_W-1:0] tag;
        logic fmt;
    } result_s;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_e;

    // Applies one received word to the program registers
    function automatic cfg_s apply_word(cfg_s cur, logic [CFG_W-1:0] w);
        cfg_s nxt;
        nxt = cur;
        case (w[CMD_LSB +: CMD_W])
            PROGRAM_WRITE_CMD: begin
                nxt.chan = w[CHAN_LSB +: CHAN_W];
                nxt.full_scale_span = w[SPAN_LSB +: SPAN_W];
                nxt.fmt = w[FMT_POS];
                nxt.programmed = 1'b1;
            end
            FIXED_CHANNEL_SELECT_CMD: begin
                nxt.running = cur.programmed;
                nxt.auto_seq = 1'b0;
            end
            AUTO_SEQUENCE_CMD: begin
                nxt.running = cur.programmed;
                nxt.auto_seq = 1'b1;
                nxt.chan = CHAN_RST;
            end
            default: begin
                nxt = cur;
            end
        endcase
        return nxt;
    endfunction : apply_word

endpackage : adc_frame_pkg

// ### design/sync3.sv
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic dout_q;

    // Three stages; only the second reads the first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once the last two stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout_q <= RST_VAL;
        end else if (s2_q == s3_q) begin
            dout_q <= s2_q;
        end
    end

    assign dout = dout_q;

endmodule : sync3
`default_nettype wire

// ### design/conv_core.sv
`timescale 1ns/1ps
`default_nettype none
module conv_core import adc_frame_pkg::*; #(
    parameter int NCH = 8,
    parameter int CYC = CONV_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic idle,
    input wire logic [CHAN_W-1:0] chan,
    input wire logic [SPAN_W-1:0] span,
    input wire logic fmt,
    input wire logic [NCH-1:0][CODE_W-1:0] ain_code,
    output result_s res,
    output logic done,
    output logic busy
);
    localparam int CNT_W = $clog2(CYC + 1);

    conv_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    result_s res_q;
    logic done_q;

    // Sequencer: sample on start, then run a fixed count on the local clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= CONV_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                CONV_IDLE: begin
                    if (start) begin
                        state_q <= CONV_BUSY;
                        cnt_q <= CNT_W'(CYC - 1);
                    end
                end
                CONV_BUSY: begin
                    if (cnt_q == '0) begin
                        state_q <= CONV_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= CONV_IDLE;
                end
            endcase
        end
    end

    // Held sample; codes pass unchanged as straight binary
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_q <= '0;
        end else if (start && state_q == CONV_IDLE) begin
            res_q.code <= ain_code[chan];
            res_q.tag <= {1'b0, chan, 1'b0, span};
            res_q.fmt <= fmt;
        end
    end

    // Ready flag; cleared while deselected so no stale result crosses
    always_ff @(posedge mclk) begin
        if (!rst_n || idle || start) begin
            done_q <= 1'b0;
        end else if (state_q == CONV_BUSY && cnt_q == '0) begin
            done_q <= 1'b1;
        end
    end

    assign res = res_q;
    assign done = done_q;
    assign busy = state_q[1]; // One-hot busy bit, so the flag comes straight from a flop

    sequence s_last_count;
        state_q == CONV_BUSY && cnt_q == '0;
    endsequence

    property p_done_after_count;
        @(posedge mclk) disable iff (!rst_n)
        s_last_count and !idle && !start |=> done_q;
    endproperty

    a_conv_done_time: assert property (p_done_after_count)
        else $error("Conversion did not finish on its count");

    a_sample_channel: assert property (@(posedge mclk) disable iff (!rst_n)
        (start && state_q == CONV_IDLE) |=> res_q.code == $past(ain_code[chan]))
        else $error("Sampled code is not from the chosen channel");

endmodule : conv_core
`default_nettype wire

// ### design/adc_serial_frame_interface.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_frame_interface import adc_frame_pkg::*; #(
    parameter int NCH = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic daisy_in,
    input wire logic reset_powerdown_pin_n,
    input wire logic [NCH-1:0][CODE_W-1:0] ain_code,
    output logic sdo,
    output logic sdo_oe,
    output logic low_power_state,
    output logic conv_busy
);
    localparam logic [4:0] EDGE_MSB = 5'(CFG_EDGES - 1);
    localparam logic [4:0] EDGE_DONE = 5'(CFG_EDGES);
    localparam logic [7:0] PD_COUNT = 8'(PD_CYCLES);
    localparam logic [7:0] RST_MAX_COUNT = 8'(RST_MAX_CYCLES);
    localparam logic [3:0] TAG_COUNT = 4'(TAG_W);

    // ---------------- Local clock domain ----------------
    logic cs_lvl;
    logic rpd_lvl;
    logic tgl_lvl;
    logic cs_prev_q;
    logic cs_fall;
    logic [7:0] low_cnt_q;
    logic low_power_q;
    logic tgl_seen_q;
    logic pend_q;
    logic [CFG_W-1:0] pend_word_q;
    cfg_s cfg_q;
    cfg_s cfg_d;
    logic start;
    logic sdo_oe_q;
    result_s res;
    logic res_done;

    // ---------------- Link clock domain ----------------
    logic [4:0] cnt_q;
    logic [CFG_W-1:0] cfg_sh_q;
    logic [CFG_W-1:0] cfg_word_q;
    logic cfg_tgl_q;
    logic done_meta_q;
    logic done_sync_q;
    logic [CODE_W-1:0] shreg_q;
    logic [TAG_W-1:0] tag_q;
    logic [3:0] tag_left_q;

    // Pins and the link toggle enter through three stages each
    sync3 #(.RST_VAL(1'b1)) u_cs_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din(cs_n),
        .dout(cs_lvl)
    );

    sync3 #(.RST_VAL(1'b1)) u_rpd_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din(reset_powerdown_pin_n),
        .dout(rpd_lvl)
    );

    sync3 #(.RST_VAL(1'b0)) u_tgl_sync (
        .clk(mclk),
        .rst_n(rst_n),
        .din(cfg_tgl_q),
        .dout(tgl_lvl)
    );

    // Pulse width of the reset/power-down pin, saturating
    always_ff @(posedge mclk) begin
        if (!rst_n || rpd_lvl) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != PD_COUNT) begin
            low_cnt_q <= low_cnt_q + 8'h01;
        end
    end

    // Only a pulse of the full power-down width enters low power
    always_ff @(posedge mclk) begin
        if (!rst_n || rpd_lvl) begin
            low_power_q <= 1'b0;
        end else if (low_cnt_q == PD_COUNT - 8'h01) begin
            low_power_q <= 1'b1;
        end
    end

    // Frame start seen once the synchronised select settles low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cs_prev_q <= 1'b1;
        end else begin
            cs_prev_q <= cs_lvl;
        end
    end

    // Inputs other than the pin are ignored while held in reset or low power
    assign cs_fall = cs_prev_q && !cs_lvl && rpd_lvl && !low_power_q;

    // A finished word waits here until the next frame start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tgl_seen_q <= 1'b0;
            pend_q <= 1'b0;
            pend_word_q <= '0;
        end else begin
            tgl_seen_q <= tgl_lvl;
            if (tgl_lvl != tgl_seen_q && rpd_lvl) begin
                pend_q <= 1'b1; // Arrival wins over a same-cycle consume
                pend_word_q <= cfg_word_q;
            end else if (cs_fall || !rpd_lvl) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Program registers as they stand after this frame start
    always_comb begin
        cfg_d = cfg_q;
        if (pend_q) begin
            cfg_d = apply_word(cfg_q, pend_word_q);
        end
    end

    assign start = cs_fall && cfg_d.running;

    // Registers change only at a frame start; any pin pulse resets them
    always_ff @(posedge mclk) begin
        if (!rst_n || !rpd_lvl) begin
            cfg_q <= CFG_RST;
        end else if (cs_fall) begin
            cfg_q <= cfg_d;
            if (cfg_d.auto_seq) begin
                cfg_q.chan <= (cfg_d.chan == CHAN_W'(NCH - 1)) ? CHAN_RST
                              : cfg_d.chan + 3'h1;
            end
        end
    end

    // Sampling and conversion on the local clock, not the link clock
    conv_core #(.NCH(NCH), .CYC(CONV_CYCLES)) u_core (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(start),
        .idle(cs_lvl),
        .chan(cfg_d.chan),
        .span(cfg_d.full_scale_span),
        .fmt(cfg_d.fmt),
        .ain_code(ain_code),
        .res(res),
        .done(res_done),
        .busy(conv_busy)
    );

    // Output enable follows select; a few cycles late through the synchroniser
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sdo_oe_q <= 1'b0;
        end else begin
            sdo_oe_q <= !cs_lvl && rpd_lvl && !low_power_q;
        end
    end

    assign sdo_oe = sdo_oe_q;
    assign low_power_state = low_power_q;

    // Link edge counter; select high clears it so every frame restarts
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= '0;
        end else if (cnt_q != EDGE_DONE) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Configuration bits, MSB first, on the first edges only
    always_ff @(negedge sclk) begin
        if (!cs_n && cnt_q < EDGE_DONE) begin
            cfg_sh_q <= {cfg_sh_q[CFG_W-2:0], sdi};
        end
        if (!cs_n && cnt_q == EDGE_MSB) begin
            cfg_word_q <= {cfg_sh_q[CFG_W-2:0], sdi};
        end
    end

    // Event toggle to the local domain; word is stable long before use
    always_ff @(negedge sclk or negedge reset_powerdown_pin_n) begin
        if (!reset_powerdown_pin_n) begin
            cfg_tgl_q <= 1'b0;
        end else if (!cs_n && cnt_q == EDGE_MSB) begin
            cfg_tgl_q <= !cfg_tgl_q;
        end
    end

    // Result ready crosses as a level; the result word is held behind it
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            done_meta_q <= 1'b0;
            done_sync_q <= 1'b0;
        end else begin
            done_meta_q <= res_done;
            done_sync_q <= done_meta_q;
        end
    end

    // Output shifter: zeros, then MSB at the 16th edge, then tag and chain
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            shreg_q <= '0;
            tag_q <= '0;
            tag_left_q <= '0;
        end else if (cnt_q == EDGE_MSB) begin
            if (done_sync_q) begin
                shreg_q <= res.code;
                tag_q <= res.tag;
                tag_left_q <= res.fmt ? TAG_COUNT : 4'h0;
            end else begin
                shreg_q <= '0; // Host clocked too fast: no result yet
            end
        end else if (cnt_q == EDGE_DONE) begin
            if (tag_left_q != 4'h0) begin
                shreg_q <= {shreg_q[CODE_W-2:0], tag_q[TAG_W-1]};
                tag_q <= {tag_q[TAG_W-2:0], 1'b0};
                tag_left_q <= tag_left_q - 4'h1;
            end else begin
                shreg_q <= {shreg_q[CODE_W-2:0], daisy_in};
            end
        end
    end

    // Before the 16th edge nothing is loaded, so the pin stays low
    assign sdo = shreg_q[CODE_W-1];

    sequence s_msb_edge;
        cnt_q == EDGE_MSB && done_sync_q;
    endsequence

    sequence s_shift_edge;
        cnt_q == EDGE_DONE && tag_left_q == 4'h0;
    endsequence

    a_sdo_quiet_early: assert property (@(negedge sclk) disable iff (cs_n)
        (cnt_q < EDGE_MSB) |-> (shreg_q == '0))
        else $error("Serial output not low before the 16th edge");

    a_msb_at_edge16: assert property (@(negedge sclk) disable iff (cs_n)
        s_msb_edge |=> (sdo == $past(res.code[CODE_W-1])) && cnt_q == EDGE_DONE)
        else $error("Result MSB not presented at the 16th edge");

    a_chain_capture: assert property (@(negedge sclk) disable iff (cs_n)
        s_shift_edge |=> (shreg_q[0] == $past(daisy_in))
        && (shreg_q[CODE_W-1:1] == $past(shreg_q[CODE_W-2:0])))
        else $error("Chain input not shifted in");

    a_cfg_word_take: assert property (@(negedge sclk) disable iff (cs_n)
        (cnt_q == EDGE_MSB) |=> (cfg_word_q == $past({cfg_sh_q[CFG_W-2:0], sdi})))
        else $error("Configuration word not taken at the 16th edge");

    a_tag_length: assert property (@(negedge sclk) disable iff (cs_n)
        (s_msb_edge ##0 res.fmt) |=> (tag_left_q == TAG_COUNT))
        else $error("Tagged format did not extend the frame");

    a_oe_on_select: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cs_lvl && rpd_lvl && !low_power_q) |=> sdo_oe_q)
        else $error("Serial output not driven while selected");

    a_oe_idle_off: assert property (@(posedge mclk) disable iff (!rst_n)
        cs_lvl |=> !sdo_oe_q ##1 (!sdo_oe_q || !cs_lvl))
        else $error("Serial output driven while deselected");

    a_pd_long_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        (!rpd_lvl && low_cnt_q == PD_COUNT - 8'h01) |=> low_power_q && cfg_q == CFG_RST)
        else $error("Long pin pulse did not enter low power");

    a_pd_short_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        (low_cnt_q != 8'h00 && low_cnt_q <= RST_MAX_COUNT) |-> !low_power_q)
        else $error("Short pin pulse entered low power");

    a_cfg_only_start: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(cfg_q) |-> $past(cs_fall) || $past(!rpd_lvl) || $past(!rst_n))
        else $error("Configuration changed inside a frame");

    a_start_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(conv_busy) |-> $past(cs_fall) && !cs_lvl)
        else $error("Conversion began without a frame start");

    a_auto_step: assert property (@(posedge mclk) disable iff (!rst_n)
        (cs_fall && cfg_d.auto_seq && cfg_d.chan != CHAN_W'(NCH - 1))
        |=> cfg_q.chan == $past(cfg_d.chan) + 3'h1)
        else $error("Scan did not step to the next channel");

    a_no_start_unrun: assert property (@(posedge mclk) disable iff (!rst_n)
        (cs_fall && !cfg_d.running && !conv_busy) |=> !conv_busy)
        else $error("Conversion began before the device was programmed");

endmodule : adc_serial_frame_interface
`default_nettype wire

// ### sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic mclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    output logic daisy_in
);

    // Link idles deselected, serial clock parked low
    // A real rising select at start clears the link edge counter, ready and output flops, which have no other reset
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi = 1'b0;
        daisy_in = 1'b0;
        #1;
        cs_n = 1'b1;
    end

    // One frame of n falling edges; bits[k] holds sdo seen after falling edge k
    task automatic frame(input logic [15:0] word, input logic [15:0] chain, input int n,
                         output logic [63:0] bits);
        bits = '0;
        @(negedge mclk);
        cs_n = 1'b0;
        #13;
        for (int k = 1; k <= n; k++) begin
            // Past the word, sdi keeps toggling so that a late sample would show
            sdi = (k <= 16) ? word[16-k] : ~sdi;
            daisy_in = (k >= 17 && k <= 32) ? chain[32-k] : 1'b0;
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
            #20;
            bits[k] = sdo_oe ? sdo : ~sdo; // Released pin read as the inverse of its last value
            #20;
        end
        @(negedge mclk);
        cs_n = 1'b1;
        sdi = ~sdi;
        daisy_in = 1'b0;
    endtask : frame

endmodule : host_model
`default_nettype wire

// ### sim/adc_serial_frame_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_frame_interface_tb import adc_frame_pkg::*;;
    localparam int NCH = 8;
    logic mclk, rst_n, sclk, cs_n, sdi, daisy_in, reset_powerdown_pin_n;
    logic sdo, sdo_oe, low_power_state, conv_busy;
    logic [NCH-1:0][CODE_W-1:0] ain_code;
    logic [63:0] bits;
    logic oe_s, busy_s;
    int errors, comparisons;

    adc_serial_frame_interface #(.NCH(NCH)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .daisy_in(daisy_in), .reset_powerdown_pin_n(reset_powerdown_pin_n),
        .ain_code(ain_code), .sdo(sdo), .sdo_oe(sdo_oe),
        .low_power_state(low_power_state), .conv_busy(conv_busy)
    );

    host_model u_host (
        .mclk(mclk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .daisy_in(daisy_in)
    );

    // Local clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Distinct code per channel, MSB set so a missing result cannot pass
    function automatic logic [15:0] code_of(input int ch);
        return 16'hc3a0 | 16'(ch);
    endfunction : code_of

    function automatic logic [15:0] prog(input logic [2:0] ch, input logic [2:0] sp,
                                         input logic fmt);
        return {PROGRAM_WRITE_CMD, 3'h0, fmt, 1'b0, sp, 1'b0, ch};
    endfunction : prog

    // Gathers len captured bits, first one becomes the MSB
    function automatic logic [31:0] field(input logic [63:0] b, input int first, input int len);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < len; i++) v = {v[30:0], b[first+i]};
        return v;
    endfunction : field

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Frame plus a look at the enable and busy flags early in the frame, then idle check
    task automatic run(input logic [15:0] word, input logic [15:0] chain, input int n);
        fork
            u_host.frame(word, chain, n, bits);
            begin
                repeat (12) @(posedge mclk);
                #1;
                oe_s = sdo_oe;
                busy_s = conv_busy;
            end
        join
        repeat (10) @(negedge mclk);
        check("sdo_oe_idle", 32'(sdo_oe), 32'h0);
    endtask : run

    // Programme channel 3, then start fixed-channel conversions
    task automatic t_start();
        run(prog(3'h3, 3'h2, 1'b0), 16'h0, 16);
        check("busy_unstarted", 32'(busy_s), 32'h0);
        run({FIXED_CHANNEL_SELECT_CMD, 12'h000}, 16'h0, 16);
    endtask : t_start

    // Result of channel 3 with chain data behind it; reprogramme channel 5
    task automatic t_chain();
        run(prog(3'h5, 3'h1, 1'b0), 16'h5a3c, 48);
        check("oe_in_frame", 32'(oe_s), 32'h1);
        check("busy_in_frame", 32'(busy_s), 32'h1);
        check("lead_zeros", field(bits, 1, 15), 32'h0);
        check("result_ch3", field(bits, 16, 16), 32'(code_of(3)));
        check("chain_data", field(bits, 32, 16), 32'h5a3c);
    endtask : t_chain

    // Channel 5 now converts; word for tagged format sent with channel 6
    task automatic t_next();
        run(prog(3'h6, 3'h3, 1'b1), 16'h0, 40);
        check("result_ch5", field(bits, 16, 16), 32'(code_of(5)));
        check("tail_low", field(bits, 32, 8), 32'h0);
    endtask : t_next

    // Tagged format adds 8 bits after the result
    task automatic t_tagged();
        run(16'h0000, 16'h0, 40);
        check("lead_zeros_t", field(bits, 1, 15), 32'h0);
        check("result_ch6", field(bits, 16, 16), 32'(code_of(6)));
        check("tag_bits", field(bits, 32, 8), 32'h63);
    endtask : t_tagged

    // Short pulse resets registers without power-down; fixed command refused
    task automatic t_short();
        int hi;
        hi = 0;
        reset_powerdown_pin_n = 1'b0;
        repeat (20) @(negedge mclk);
        reset_powerdown_pin_n = 1'b1;
        repeat (40) begin
            @(negedge mclk);
            if (low_power_state !== 1'b0) hi++;
        end
        check("no_power_down", 32'(hi), 32'h0);
        run({FIXED_CHANNEL_SELECT_CMD, 12'h000}, 16'h0, 16);
        run({FIXED_CHANNEL_SELECT_CMD, 12'h000}, 16'h0, 16);
        check("busy_after_reset", 32'(busy_s), 32'h0);
    endtask : t_short

    // Long pulse enters power-down; frames meanwhile are ignored
    task automatic t_long();
        reset_powerdown_pin_n = 1'b0;
        repeat (120) @(negedge mclk);
        check("power_down", 32'(low_power_state), 32'h1);
        run(prog(3'h1, 3'h0, 1'b0), 16'h0, 16);
        check("oe_in_pd", 32'(oe_s), 32'h0);
        reset_powerdown_pin_n = 1'b1;
        repeat (20) @(negedge mclk);
        check("wake", 32'(low_power_state), 32'h0);
    endtask : t_long

    // Scan mode: starts at channel 0 and steps one channel per frame
    task automatic t_auto();
        run(prog(3'h4, 3'h0, 1'b0), 16'h0, 16);
        run({AUTO_SEQUENCE_CMD, 12'h000}, 16'h0, 16);
        run(16'h0000, 16'h0, 32);
        check("result_auto0", field(bits, 16, 16), 32'(code_of(0)));
        run(16'h0000, 16'h0, 32);
        check("result_auto1", field(bits, 16, 16), 32'(code_of(1)));
    endtask : t_auto

    // Guard against a hung run
    initial begin
        repeat (90000) @(posedge mclk);
        errors++;
        end_sim();
    end

    // Pin held low with rst_n so the pin logic starts from a known state
    initial begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        reset_powerdown_pin_n = 1'b1;
        for (int i = 0; i < NCH; i++) ain_code[i] = code_of(i);
        // A real falling edge on the pin clears the link toggle, which has no other reset
        #1;
        reset_powerdown_pin_n = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        reset_powerdown_pin_n = 1'b1;
        repeat (10) @(negedge mclk);
        check("oe_after_reset", 32'(sdo_oe), 32'h0);
        t_start();
        t_chain();
        t_next();
        t_tagged();
        t_short();
        t_long();
        t_auto();
        end_sim();
    end

endmodule : adc_serial_frame_interface_tb
`default_nettype wire
